/* File: ias_pkg.sv */
// Constants, register map and carrier types of the address-match
// and direction status block. Assumes an AXI4-Lite master on aclk.
// How it works
// - Status write also clears arbitration-lost flag
// - Own address match sets flag at eighth rise
// - Start, stop, leave, disable clear address match
// - Direction zero keeps data line released
// - Direction one drives latch: slave after ninth fall, master at once
// - Stop, leave, disable, release, first loss clear direction
// - Master sending read bit clears direction
// - Slave start or write bit clears direction
// - Master start or write bit sets direction
// - Slave receiving read bit with own address match sets direction
// - Wait release clears direction, releases line
// - Leave is control bit 6, enable bit 7
// - Loss sets flag, drops master; read clears
package ias_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STAT = 5'h04;
   localparam logic [4:0] OFF_OWN = 5'h08;
   localparam logic [4:0] OFF_IRQ = 5'h0C;
   localparam logic [4:0] OFF_MASK = 5'h10;
   localparam int CTRL_ENABLE = 7;
   localparam int CTRL_LEAVE = 6;
   localparam int CTRL_WREL = 5;
   localparam int IRQ_W = 4;
   localparam int IRQ_MATCH = 0;
   localparam int IRQ_ARB = 1;
   localparam int IRQ_START = 2;
   localparam int IRQ_STOP = 3;
   localparam logic [7:0] OWN_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // Serial clock counts
   // ------------------------------------------------------------
   localparam logic [3:0] CNT_LSB = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h9;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} ias_wr_t;
   typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} ias_rd_t;
   typedef struct packed {
      logic master;
      logic arb_lost;
      logic addr_match;
      logic direction;
   } ias_flags_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } ias_edges_t;
endpackage

/* File: ias_top.sv */
// Address-match and direction status logic with AXI4-Lite registers.
// Assumes scl/sda come from the bus pins (asynchronous) and that the
// master engine and arbitration logic share aclk.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module ias_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [ias_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ias_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Serial bus pins
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic serial_data_line_out,
   output logic serial_data_line_oe,
   // Same-clock master engine
   input wire logic start_generated,
   input wire logic arbitration_loss,
   input wire logic shift_out_latch,
   // Status and interrupt
   output ias_pkg::ias_flags_t flags,
   output logic irq
);
   import ias_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ias_wr_t wr_state, next_wr_state;
   ias_rd_t rd_state, next_rd_state;
   logic aw_got, next_aw_got, w_got, next_w_got;
   logic [ADDR_W-1:0] waddr, next_waddr;
   logic [31:0] wdat, next_wdat;
   logic [3:0] wstb, next_wstb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic do_wr, rd_stat, rd_irq;
   logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
   ias_edges_t ev;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [6:0] shreg, next_shreg;
   logic first_byte, next_first_byte, armed, next_armed;
   logic enable, next_enable, en_prev;
   logic [7:0] own, next_own;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat, mask, next_mask;
   ias_flags_t next_flags;
   logic next_oe, next_irq, leave, wrel, en_fall, lsb_now, hit;

   // Legal register word
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFF_CTRL) || (a == OFF_STAT) || (a == OFF_OWN) ||
               (a == OFF_IRQ) || (a == OFF_MASK);
   endfunction

   // ------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ------------------------------------------------------------
   always_comb begin
      next_wr_state = wr_state;
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_waddr = waddr;
      next_wdat = wdat;
      next_wstb = wstb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      do_wr = 1'b0;
      if (awvalid && awready) begin
         next_aw_got = 1'b1;
         next_waddr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_got = 1'b1;
         next_wdat = wdata;
         next_wstb = wstrb;
      end
      unique case (wr_state)
         WR_IDLE: begin
            if (next_aw_got && next_w_got) begin
               do_wr = mapped(next_waddr);
               next_bvalid = 1'b1;
               next_bresp = mapped(next_waddr) ? RESP_OKAY : RESP_SLVERR;
               next_aw_got = 1'b0;
               next_w_got = 1'b0;
               next_wr_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (bready) begin
               next_bvalid = 1'b0;
               next_wr_state = WR_IDLE;
            end
         end
      endcase
      next_awready = !next_aw_got && (next_wr_state == WR_IDLE);
      next_wready = !next_w_got && (next_wr_state == WR_IDLE);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= WR_IDLE;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= '0;
         wdat <= '0;
         wstb <= 4'h0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         waddr <= next_waddr;
         wdat <= next_wdat;
         wstb <= next_wstb;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
      end
   end

   // ------------------------------------------------------------
   // Read channel: one answer per address, reads may clear flags
   // ------------------------------------------------------------
   always_comb begin
      next_rd_state = rd_state;
      next_arready = arready;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      rd_stat = 1'b0;
      rd_irq = 1'b0;
      unique case (rd_state)
         RD_IDLE: begin
            if (arvalid && arready) begin
               rd_stat = (araddr == OFF_STAT);
               rd_irq = (araddr == OFF_IRQ);
               next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
               next_rdata = 32'h0000_0000;
               unique case (araddr)
                  OFF_CTRL: next_rdata[CTRL_ENABLE] = enable;
                  OFF_STAT: next_rdata[7:0] = {flags.master, flags.arb_lost,
                     1'b0, flags.addr_match, flags.direction, 3'h0};
                  OFF_OWN: next_rdata[7:0] = own;
                  OFF_IRQ: next_rdata[IRQ_W-1:0] = irq_stat;
                  OFF_MASK: next_rdata[IRQ_W-1:0] = mask;
                  default: next_rdata = 32'h0000_0000;
               endcase
               next_rvalid = 1'b1;
               next_arready = 1'b0;
               next_rd_state = RD_DATA;
            end
         end
         RD_DATA: begin
            if (rready) begin
               next_rvalid = 1'b0;
               next_arready = 1'b1;
               next_rd_state = RD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= RD_IDLE;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         rd_state <= next_rd_state;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // ------------------------------------------------------------
   // Link sampling and byte framing
   // ------------------------------------------------------------
   // Edges look only at the second and third stages, never the first
   assign ev.start = scl_sync && scl_prev && sda_prev && !sda_sync;
   assign ev.stop = scl_sync && scl_prev && !sda_prev && sda_sync;
   assign ev.rise = scl_sync && !scl_prev;
   assign ev.fall = !scl_sync && scl_prev;
   assign lsb_now = first_byte && ev.rise && (bit_cnt == CNT_LSB);
   assign hit = (shreg == own[7:1]);

   always_comb begin
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_first_byte = first_byte;
      if (ev.start || ev.stop || !enable) begin
         next_bit_cnt = 4'h0;
         next_first_byte = ev.start && enable;
      end else if (ev.rise && bit_cnt != CNT_ACK) begin
         next_bit_cnt = bit_cnt + 4'h1;
         if (bit_cnt < CNT_LSB) begin
            next_shreg = {shreg[5:0], sda_sync};
         end
      end else if (ev.fall && bit_cnt == CNT_ACK) begin
         // Ninth clock ends the byte
         next_bit_cnt = 4'h0;
         next_first_byte = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
         bit_cnt <= 4'h0;
         shreg <= 7'h00;
         first_byte <= 1'b0;
      end else begin
         scl_meta <= scl_pin;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_pin;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         first_byte <= next_first_byte;
      end
   end

   // ------------------------------------------------------------
   // Control registers, status flags and interrupt
   // ------------------------------------------------------------
   // leave and release are one-shot control bits
   assign leave = do_wr && next_waddr == OFF_CTRL && next_wstb[0] &&
                  next_wdat[CTRL_LEAVE];
   assign wrel = do_wr && next_waddr == OFF_CTRL && next_wstb[0] &&
                 next_wdat[CTRL_WREL];
   assign en_fall = en_prev && !enable;

   always_comb begin
      next_enable = enable;
      next_own = own;
      next_mask = mask;
      next_flags = flags;
      next_armed = armed;
      next_irq_stat = irq_stat;
      if (do_wr && next_wstb[0]) begin
         unique case (next_waddr)
            OFF_CTRL: next_enable = next_wdat[CTRL_ENABLE];
            OFF_OWN: next_own = next_wdat[7:0];
            OFF_MASK: next_mask = next_wdat[IRQ_W-1:0];
            default: next_own = own;
         endcase
      end
      if (ev.start || ev.stop || leave || en_fall) begin
         next_flags.addr_match = 1'b0;
         next_armed = 1'b0;
      end
      if (ev.stop || leave || en_fall || wrel ||
          (arbitration_loss && !flags.arb_lost)) begin
         next_flags.direction = 1'b0;
      end
      // wait release drops the driver as well
      if (wrel) begin
         next_armed = 1'b0;
      end
      if (ev.start && !flags.master) begin
         next_flags.direction = 1'b0;
      end
      // master status ends on stop, leave, disable, loss
      if (ev.stop || leave || en_fall || arbitration_loss) begin
         next_flags.master = 1'b0;
      end
      // read or any status write clears the loss flag
      if (rd_stat || en_fall ||
          (do_wr && next_waddr == OFF_STAT)) begin
         next_flags.arb_lost = 1'b0;
      end
      // loss sets the flag, set wins over clear
      if (arbitration_loss) begin
         next_flags.arb_lost = 1'b1;
      end
      if (start_generated && enable) begin
         next_flags.master = 1'b1;
         next_flags.direction = 1'b1;
      end
      if (lsb_now) begin
         if (flags.master) begin
            // master direction follows its own read/write bit
            next_flags.direction = !sda_sync;
         end else begin
            next_flags.addr_match = hit;
            next_flags.direction = sda_sync && hit;
         end
      end
      // output valid from the falling ninth clock
      if (first_byte && ev.fall && bit_cnt == CNT_ACK) begin
         next_armed = 1'b1;
      end
      // Read clears the sticky events; a new event still wins
      if (rd_irq) begin
         next_irq_stat = '0;
      end
      next_irq_stat[IRQ_MATCH] = next_irq_stat[IRQ_MATCH] ||
                                 (lsb_now && !flags.master && hit);
      next_irq_stat[IRQ_ARB] = next_irq_stat[IRQ_ARB] || arbitration_loss;
      next_irq_stat[IRQ_START] = next_irq_stat[IRQ_START] || ev.start;
      next_irq_stat[IRQ_STOP] = next_irq_stat[IRQ_STOP] || ev.stop;
      // driver released while direction is zero
      next_oe = next_flags.direction && enable &&
                (next_flags.master || next_armed);
      next_irq = |(next_irq_stat & next_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable <= 1'b0;
         en_prev <= 1'b0;
         own <= OWN_RST;
         mask <= MASK_RST;
         flags <= '0;
         armed <= 1'b0;
         irq_stat <= '0;
         serial_data_line_oe <= 1'b0;
         serial_data_line_out <= 1'b1;
         irq <= 1'b0;
      end else begin
         enable <= next_enable;
         en_prev <= enable;
         own <= next_own;
         mask <= next_mask;
         flags <= next_flags;
         armed <= next_armed;
         irq_stat <= next_irq_stat;
         serial_data_line_oe <= next_oe;
         serial_data_line_out <= shift_out_latch;
         irq <= next_irq;
      end
   end
endmodule // ias_top

/* File: ias_monitor.sv */
// Checker of the status flags and data line driver of ias_top.
// Sees only top ports; bound from the testbench top file.
`timescale 1ns/1ps
module ias_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes
   input wire logic [ias_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [ias_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   // Link and master engine
   input wire logic scl_pin,
   input wire logic serial_data_line_out,
   input wire logic serial_data_line_oe,
   input wire logic start_generated,
   input wire logic arbitration_loss,
   input wire logic shift_out_latch,
   // Status
   input wire ias_pkg::ias_flags_t flags
);
   import ias_pkg::*;
   logic en;
   logic next_en;
   logic wr_hit;
   logic ctrl_wr;
   // Write seen only when both halves go together, as the bench offers them
   assign wr_hit = awvalid && awready && wvalid && wready;
   assign ctrl_wr = wr_hit && awaddr == OFF_CTRL;
   // Shadow of the enable bit, so the start, loss, release and leave rules are judged only while enabled
   always_comb begin
      next_en = en;
      if (ctrl_wr) begin
         next_en = wdata[CTRL_ENABLE];
      end
   end
   always_ff @(posedge aclk) begin
      en <= aresetn ? next_en : 1'b0;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rx_float; !flags.direction |-> !serial_data_line_oe; endproperty
   a_rx_float: assert property (p_rx_float) else $error("line driven in receive");
   property p_drive; serial_data_line_oe |-> serial_data_line_out == $past(shift_out_latch);
   endproperty
   a_drive: assert property (p_drive) else $error("line not the latch value");
   property p_start; en && start_generated && !arbitration_loss |=> flags.master && flags.direction;
   endproperty
   a_start: assert property (p_start) else $error("start did not set direction");
   // Direction drops only when the loss flag rises, not on a repeated loss
   property p_loss; en && arbitration_loss |=> flags.arb_lost && !flags.master &&
      ($past(flags.arb_lost) || !flags.direction);
   endproperty
   a_loss: assert property (p_loss) else $error("loss flags wrong");
   property p_match; $rose(flags.addr_match) |-> scl_pin && !flags.master; endproperty
   a_match: assert property (p_match) else $error("match set off the eighth rise");
   property p_wrel; ctrl_wr && en && wdata[CTRL_WREL] |->
      ##[1:2] !flags.direction && !serial_data_line_oe; endproperty
   a_wrel: assert property (p_wrel) else $error("release kept direction");
   property p_leave; ctrl_wr && en && (wdata[CTRL_LEAVE] || !wdata[CTRL_ENABLE]) |->
      ##[1:2] !(flags.master || flags.addr_match || flags.direction); endproperty
   a_leave: assert property (p_leave) else $error("flags kept");
   property p_arb_clr; (arvalid && arready && araddr == OFF_STAT
      || wr_hit && awaddr == OFF_STAT) && !arbitration_loss |-> ##[1:2] !flags.arb_lost;
   endproperty
   a_arb_clr: assert property (p_arb_clr) else $error("loss flag kept");
endmodule // ias_monitor

/* File: ias_far_master.sv */
// Remote master on the two-wire bus, behavioural, timed in ns.
// Lines idle high as if pulled up; the bench ANDs in the device driver.
`timescale 1ns/1ps
module ias_far_master (
   // Bus lines
   output logic scl,
   output logic sda
);
   // Released bus; the clock stands still outside frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Data moves mid-low only, so no false start or stop appears
   task automatic bit_out(input logic b, input int hp);
      #(hp / 2) sda = b;
      #(hp / 2) scl = 1'b1;
      #hp scl = 1'b0;
   endtask
   // Start, also usable as a repeated start after a ninth clock
   task automatic start(input int hp);
      #(hp / 2) sda = 1'b1;
      #(hp / 2) scl = 1'b1;
      #(hp / 2) sda = 1'b0;
      #(hp / 2) scl = 1'b0;
   endtask
   // First byte, MSB first, then a released ninth clock
   task automatic frame(input logic [6:0] a, input logic rw, input int hp);
      start(hp);
      for (int i = 6; i >= 0; i--) begin
         bit_out(a[i], hp);
      end
      bit_out(rw, hp);
      bit_out(1'b1, hp);
   endtask
   task automatic stop(input int hp);
      #(hp / 2) sda = 1'b0;
      #(hp / 2) scl = 1'b1;
      #hp sda = 1'b1;
      #hp;
   endtask
endmodule // ias_far_master

/* File: ias_top_test.sv */
// Self-checking bench of ias_top with a remote bus master model.
// Inputs change at the rising edge; the run ends through finish_test.
`timescale 1ns/1ps
module ias_top_test;
   import ias_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic start_generated = 1'b0, arbitration_loss = 1'b0, shift_out_latch = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, irq, sdo, soe, scl, far_sda, m, d;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, rv;
   ias_flags_t flags;
   int n_mismatch = 0;
   int check_count = 0;
   logic [8:0] rows [4] = '{{7'h2D, 2'b11}, {7'h2D, 2'b01}, {7'h2C, 2'b10}, {7'h6D, 2'b10}};
   // Open-drain data wire: low wins
   wire sda = far_sda & (soe ? sdo : 1'b1);
   always #2.5 aclk = ~aclk;
   ias_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .scl_pin(scl), .sda_pin(sda), .serial_data_line_out(sdo), .serial_data_line_oe(soe),
      .start_generated(start_generated), .arbitration_loss(arbitration_loss),
      .shift_out_latch(shift_out_latch), .flags(flags), .irq(irq));
   ias_far_master far (.scl(scl), .sda(far_sda));
   task automatic finish_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic timeout;
      n_mismatch++;
      finish_test();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cf(input logic [3:0] e);
      chk(32'(flags), 32'(e));
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Engine pulses never share an edge, so no signal is driven twice
   task automatic pulse(input logic loss);
      @(posedge aclk);
      start_generated <= !loss;
      arbitration_loss <= loss;
      @(posedge aclk);
      start_generated <= 1'b0;
      arbitration_loss <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      rr = bresp;
      if (n == 100) timeout();
   endtask
   task automatic rd(input logic [4:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rv = rdata;
      rr = rresp;
      if (n == 100) timeout();
   endtask
   initial begin
      tick(5);
      aresetn <= 1'b1;
      tick(1);
      cf(4'h0);
      rd(OFF_OWN);
      chk(rv, 32'(OWN_RST));
      rd(5'h14);
      chk({rv[29:0], rr}, {30'h0, RESP_SLVERR});
      wr(OFF_OWN, 32'h5A);
      wr(5'h14, 32'h1);
      chk(32'(rr), 32'(RESP_SLVERR));
      // Only byte lane 0 writes; a cleared strobe leaves the address alone
      wstrb <= 4'hE;
      wr(OFF_OWN, 32'hFF);
      wstrb <= 4'hF;
      rd(OFF_OWN);
      chk(rv, 32'h5A);
      wr(OFF_MASK, 32'h1);
      wr(OFF_CTRL, 32'h80);
      rd(OFF_CTRL);
      chk(rv, 32'h80);
      // Ordinary first bytes: match, direction, driver and interrupt
      foreach (rows[i]) begin
         far.frame(rows[i][8:2], rows[i][1], 40);
         tick(8);
         m = rows[i][0];
         d = m & rows[i][1];
         cf({2'b00, m, d});
         chk(32'(soe), 32'(d));
         chk(32'(irq), 32'(m));
         rd(OFF_IRQ);
         chk(32'(rv[IRQ_MATCH]), 32'(m));
         tick(2);
         chk(32'(irq), 32'h0);
         far.stop(40);
         tick(8);
         cf(4'h0);
      end
      // Remote read, then wait release and a repeated start
      far.frame(7'h2D, 1'b1, 40);
      tick(8);
      chk(32'(soe), 32'h1);
      wr(OFF_CTRL, 32'hA0);
      tick(3);
      cf(4'h2);
      chk(32'(soe), 32'h0);
      far.frame(7'h2D, 1'b1, 40);
      tick(8);
      far.start(40);
      tick(8);
      cf(4'h0);
      far.stop(40);
      // Leave request drops the match
      far.frame(7'h2D, 1'b0, 40);
      tick(8);
      cf(4'h2);
      wr(OFF_CTRL, 32'hC0);
      tick(3);
      cf(4'h0);
      far.stop(40);
      tick(8);
      // Own master: clock held low so a driven zero is no start
      far.scl = 1'b0;
      pulse(1'b0);
      tick(2);
      cf(4'h9);
      chk(32'(soe), 32'h1);
      shift_out_latch <= 1'b0;
      tick(3);
      chk(32'(sda), 32'h0);
      shift_out_latch <= 1'b1;
      pulse(1'b1);
      tick(2);
      cf(4'h4);
      chk(32'(soe), 32'h0);
      rd(OFF_STAT);
      chk(rv, 32'h40);
      cf(4'h0);
      pulse(1'b0);
      pulse(1'b1);
      tick(2);
      cf(4'h4);
      wr(OFF_STAT, 32'h00);
      chk(32'(rr), 32'(RESP_OKAY));
      tick(2);
      cf(4'h0);
      far.scl = 1'b1;
      tick(8);
      // Own master first byte: its read/write bit on the line picks direction
      pulse(1'b0);
      far.frame(7'h2D, 1'b1, 40);
      tick(8);
      cf(4'h8);
      far.frame(7'h2D, 1'b0, 40);
      tick(8);
      cf(4'h9);
      far.stop(40);
      tick(8);
      cf(4'h0);
      // Disable clears every flag and stops byte framing
      far.frame(7'h2D, 1'b1, 40);
      tick(8);
      wr(OFF_CTRL, 32'h00);
      tick(3);
      cf(4'h0);
      far.stop(40);
      far.frame(7'h2D, 1'b1, 40);
      tick(8);
      cf(4'h0);
      far.stop(40);
      // Reset in mid-run drops every flag, the driver and the enable bit
      wr(OFF_CTRL, 32'h80);
      pulse(1'b0);
      aresetn <= 1'b0;
      tick(5);
      aresetn <= 1'b1;
      tick(1);
      cf(4'h0);
      chk(32'(soe), 32'h0);
      chk(32'(irq), 32'h0);
      rd(OFF_CTRL);
      chk(rv, 32'h0);
      finish_test();
   end
endmodule // ias_top_test
bind ias_top ias_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
   .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
   .araddr(araddr), .arvalid(arvalid), .arready(arready), .scl_pin(scl_pin),
   .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
   .start_generated(start_generated), .arbitration_loss(arbitration_loss),
   .shift_out_latch(shift_out_latch), .flags(flags));
